// [include/dac_cmd_pkg.sv]
// Constants and types of the serial command port of the eight-channel DAC
// What this block does and what it expects of the host
// R1: A command frame is sixteen falling clock edges while frame-sync is low.
// R2: Each falling edge after frame-sync low shifts the data input in.
// R3: Host never lowers frame-sync on a falling clock edge.
// R4: The decoded command executes only when frame-sync rises after a full frame.
// R5: A single-device host raises frame-sync between edges sixteen and seventeen.
// R6: Frame-sync rising before edge fifteen aborts and discards the frame.
// R7: From edge sixteen on, the received input bits appear on the serial output.
// R8: Host holds frame-sync high for its minimum time between frames.
// R9: Host idles frame-sync high so the chain output stays quiet.
// R10: A chain of n devices takes n times sixteen edges; one rise executes all.
// R11: Serial output low for fourteen edges, high on fifteenth, then input bits.
// R12: Serial output comes from the shift register end on falling edges.
// R13: Frames are MSB first: four command bits, then twelve data bits.
// R14: Command codes 0000 to 0111 write channel one to eight data registers.
// R15: Code 1000 selects register-only mode, 1001 write-through mode.
// R16: 1010 update select or regulator, 1011 channel-one write, 1100 broadcast.
// R17: Codes 1101, 1110, 1111 power down channels: high-Z, 100k, 2.5k.
// R18: Powered-down channels keep their registers and still accept new values.
// R19: Leaving power-down, a channel waits a recovery delay before settling.
// R20: After reset the block is in register-only mode.
// R21: Register-only writes touch the register; write-through also the output.
// R22: Channel-one write loads channel one and updates all outputs, mode kept.
// R23: Broadcast loads all eight registers and outputs with the data.
// R24: A rise between edges fifteen and sixteen is incomplete; nothing executes.
// R25: Mode-change commands ignore their twelve data bits.
package dac_cmd_pkg;

  localparam int FRAME_BITS = 16;
  localparam int CH_NUM = 8;
  localparam int CODE_W = 12;
  localparam int CNT_W = 5;

  // Edge counter marks
  localparam logic [CNT_W-1:0] CNT_SAT = 5'h1F;
  localparam logic [CNT_W-1:0] DOUT_LOW_LAST = 5'h0E;
  localparam logic [CNT_W-1:0] DOUT_MARK = 5'h0F;
  localparam logic [CNT_W-1:0] FRAME_FULL = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

  // Command codes in the top four frame bits
  localparam logic [3:0] CMD_REG_ONLY = 4'h8;
  localparam logic [3:0] CMD_WRITE_THROUGH = 4'h9;
  localparam logic [3:0] CMD_UPDATE_SEL = 4'hA;
  localparam logic [3:0] CMD_CH1_WRITE = 4'hB;
  localparam logic [3:0] CMD_BROADCAST = 4'hC;
  localparam logic [3:0] CMD_PD_HIZ = 4'hD;
  localparam logic [3:0] CMD_PD_100K = 4'hE;
  localparam logic [3:0] CMD_PD_2K5 = 4'hF;
  localparam int SPECIAL_BIT = 3;

  // Data field layout of special commands
  localparam int MASK_LSB = 0;
  localparam int REG_EN_BIT = 8;

  // Power-down recovery
  localparam int WAKE_TIME_NS = 8000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int WAKE_W = 11;
  localparam logic [WAKE_W-1:0] WAKE_CYCLES =
    WAKE_W'((WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [WAKE_W-1:0] WAKE_ONE = 11'h001;
  localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
  localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 16'h0000;

  typedef struct packed {
    logic [3:0] addr;
    logic [CODE_W-1:0] data;
  } frame_t;

  typedef enum logic [1:0] {TERM_NONE, TERM_HIZ, TERM_100K, TERM_2K5} term_t;

  typedef logic [CH_NUM-1:0][CODE_W-1:0] code_arr_t;
  typedef term_t [CH_NUM-1:0] term_arr_t;

endpackage

// [hw/frame_shifter.sv]
// Serial-clock side: shift register, edge counter and chain output
`timescale 1ns/1ps
`default_nettype none
module frame_shifter
  import dac_cmd_pkg::*;
(
  // Link
  input wire logic sclk_i,
  input wire logic arst_n_i,
  input wire logic sync_n_i,
  input wire logic din_i,
  // Frame out
  output frame_t word_o,
  output logic full_o,
  output logic dout_o
);

  logic [CNT_W-1:0] edge_cnt;
  logic [CNT_W-1:0] next_edge_cnt;
  logic [FRAME_BITS-1:0] shreg;
  logic [FRAME_BITS-1:0] next_shreg;
  logic cnt_rst_n;

  // Counter cleared while frame-sync is high
  assign cnt_rst_n = arst_n_i & ~sync_n_i; // [R6]
  assign next_edge_cnt = (edge_cnt == CNT_SAT) ? CNT_SAT : edge_cnt + CNT_ONE;
  assign next_shreg = {shreg[FRAME_BITS-2:0], din_i}; // [R2] [R13]

  always_ff @(negedge sclk_i or negedge cnt_rst_n) begin
    if (!cnt_rst_n) begin
      edge_cnt <= CNT_ZERO;
    end else begin
      edge_cnt <= next_edge_cnt; // [R1]
    end
  end

  always_ff @(negedge sclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shreg <= SHIFT_RESET;
    end else begin
      shreg <= next_shreg; // [R2]
    end
  end

  // Frame word and completeness, stable while the clock rests
  assign word_o = frame_t'(shreg); // [R13]

  always_ff @(negedge sclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      full_o <= 1'b0;
    end else begin
      full_o <= (next_edge_cnt >= FRAME_FULL); // [R24] [R10]
    end
  end

  // Chain output
  always_ff @(negedge sclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dout_o <= 1'b0;
    end else if (next_edge_cnt <= DOUT_LOW_LAST) begin
      dout_o <= 1'b0; // [R11]
    end else if (next_edge_cnt == DOUT_MARK) begin
      dout_o <= 1'b1; // [R11]
    end else begin
      dout_o <= next_shreg[FRAME_BITS-1]; // [R7] [R12]
    end
  end

endmodule
`default_nettype wire

// [hw/dac_serial_port.sv]
// Serial command port of the eight-channel DAC
`timescale 1ns/1ps
`default_nettype none
module dac_serial_port
  import dac_cmd_pkg::*;
(
  // System clock and reset
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  // Serial link
  input wire logic SCLK_I,
  input wire logic SYNC_N_I,
  input wire logic DIN_I,
  output logic DOUT_O,
  // Channel outputs
  output code_arr_t CH_CODE_O,
  output logic [CH_NUM-1:0] CH_DOWN_O,
  output term_arr_t CH_TERM_O,
  output logic [CH_NUM-1:0] CH_SETTLED_O,
  // Status
  output logic WRITE_THROUGH_O,
  output logic REGULATOR_EN_O,
  output logic FRAME_EXEC_O
);

  frame_t link_word;
  logic link_full;
  logic sync_meta;
  logic sync_stable;
  logic sync_prev;
  logic full_meta;
  logic full_sync;
  logic armed;
  logic frame_end;
  logic exec;
  frame_t cmd;
  logic is_pd;
  term_t pd_term;

  ////////////////////////////////////////////////////////////////////////////
  // Link side

  frame_shifter u_shifter (
    .sclk_i(SCLK_I),
    .arst_n_i(ARST_N_I),
    .sync_n_i(SYNC_N_I),
    .din_i(DIN_I),
    .word_o(link_word),
    .full_o(link_full),
    .dout_o(DOUT_O)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame-sync crossing and frame end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sync_meta <= 1'b1;
      sync_stable <= 1'b1;
      sync_prev <= 1'b1;
    end else begin
      sync_meta <= SYNC_N_I;
      sync_stable <= sync_meta;
      sync_prev <= sync_stable;
    end
  end

  assign frame_end = sync_stable & ~sync_prev;
  assign is_pd = cmd.addr >= CMD_PD_HIZ; // [R17]

  // Frame-complete flag crosses through two flops
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      full_meta <= 1'b0;
      full_sync <= 1'b0;
    end else begin
      full_meta <= link_full;
      full_sync <= full_meta;
    end
  end

  // Armed once the flag drops inside a frame, so a frame without clock
  // edges cannot replay the previous command
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      armed <= 1'b0;
    end else if (frame_end) begin
      armed <= 1'b0;
    end else if (!sync_stable && !full_sync) begin
      armed <= 1'b1; // [R6]
    end
  end

  // Link word is quiet once frame-sync is high, so it is captured here
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      exec <= 1'b0;
      cmd <= frame_t'(SHIFT_RESET);
    end else begin
      exec <= frame_end & armed & full_sync; // [R4] [R6] [R24] [R10]
      if (frame_end) begin
        cmd <= link_word;
      end
    end
  end

  always_comb begin
    unique case (cmd.addr)
      CMD_PD_HIZ: pd_term = TERM_HIZ; // [R17]
      CMD_PD_100K: pd_term = TERM_100K; // [R17]
      CMD_PD_2K5: pd_term = TERM_2K5; // [R17]
      default: pd_term = TERM_NONE;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      FRAME_EXEC_O <= 1'b0;
    end else begin
      FRAME_EXEC_O <= exec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode and regulator

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      WRITE_THROUGH_O <= 1'b0; // [R20]
    end else if (exec && cmd.addr == CMD_WRITE_THROUGH) begin
      WRITE_THROUGH_O <= 1'b1; // [R15] [R25]
    end else if (exec && cmd.addr == CMD_REG_ONLY) begin
      WRITE_THROUGH_O <= 1'b0; // [R15] [R25]
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      REGULATOR_EN_O <= 1'b0;
    end else if (exec && cmd.addr == CMD_UPDATE_SEL) begin
      REGULATOR_EN_O <= cmd.data[REG_EN_BIT]; // [R16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels

  for (genvar i = 0; i < CH_NUM; i++) begin : g_ch
    logic [CODE_W-1:0] data_reg;
    logic [WAKE_W-1:0] wake_cnt;
    logic waking;
    logic sel;
    logic wr_data;
    logic upd_out;

    assign sel = cmd.data[MASK_LSB + i];
    assign wr_data = exec && (
      (!cmd.addr[SPECIAL_BIT] && cmd.addr[2:0] == 3'(i)) || // [R14]
      (cmd.addr == CMD_CH1_WRITE && i == 0) || // [R22]
      cmd.addr == CMD_BROADCAST); // [R23]
    assign upd_out = exec && (
      (!cmd.addr[SPECIAL_BIT] && cmd.addr[2:0] == 3'(i) &&
       WRITE_THROUGH_O) || // [R21]
      cmd.addr == CMD_CH1_WRITE || // [R22]
      cmd.addr == CMD_BROADCAST || // [R23]
      (cmd.addr == CMD_UPDATE_SEL && sel)); // [R16]

    // Registers accept writes even while powered down
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
        data_reg <= CODE_RESET;
      end else if (wr_data) begin
        data_reg <= cmd.data; // [R18] [R21]
      end
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
        CH_CODE_O[i] <= CODE_RESET;
      end else if (upd_out) begin
        CH_CODE_O[i] <= wr_data ? cmd.data : data_reg; // [R21] [R22]
      end
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
        CH_DOWN_O[i] <= 1'b0;
        CH_TERM_O[i] <= TERM_NONE;
      end else if (exec && is_pd) begin
        CH_DOWN_O[i] <= sel; // [R17]
        CH_TERM_O[i] <= sel ? pd_term : TERM_NONE; // [R17]
      end
    end

    // Recovery after power-down
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
        waking <= 1'b0;
        wake_cnt <= WAKE_ONE;
        CH_SETTLED_O[i] <= 1'b1;
      end else if (exec && is_pd && sel) begin
        waking <= 1'b0;
        CH_SETTLED_O[i] <= 1'b0;
      end else if (exec && is_pd && CH_DOWN_O[i]) begin
        waking <= 1'b1;
        wake_cnt <= WAKE_CYCLES; // [R19]
      end else if (waking) begin
        if (wake_cnt == WAKE_ONE) begin
          waking <= 1'b0;
          CH_SETTLED_O[i] <= 1'b1; // [R19]
        end else begin
          wake_cnt <= wake_cnt - WAKE_ONE;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [test/dac_port_monitor.sv]
// Assertion checker for the DAC serial command port
`timescale 1ns/1ps
`default_nettype none
module dac_port_monitor
  import dac_cmd_pkg::*;
(
  // Clocks, reset and link
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  input wire logic SCLK_I,
  input wire logic SYNC_N_I,
  input wire logic DIN_I,
  input wire logic DOUT_O,
  // Outputs
  input wire code_arr_t CH_CODE_O,
  input wire logic [CH_NUM-1:0] CH_DOWN_O,
  input wire logic [CH_NUM-1:0] CH_SETTLED_O,
  input wire logic WRITE_THROUGH_O,
  input wire logic FRAME_EXEC_O
);
  logic [4:0] cnt;
  logic [15:0] hist;
  ////////////////////////////////////////////////////////////////////////////
  // Falling edges in the frame and the input bit history
  always_ff @(negedge SCLK_I or posedge SYNC_N_I or negedge ARST_N_I) begin
    if (!ARST_N_I || SYNC_N_I) cnt <= 5'h00;
    else if (cnt != 5'h1F) cnt <= cnt + 5'h01;
  end
  always_ff @(negedge SCLK_I) begin
    hist <= {hist[14:0], DIN_I};
  end
  ////////////////////////////////////////////////////////////////////////////
  a_exec_after_sync: assert property (
    @(posedge REF_CLK_I) disable iff (!ARST_N_I)
    FRAME_EXEC_O |-> SYNC_N_I && $past(SYNC_N_I)) else $error("early exec");
  a_exec_one_pulse: assert property (
    @(posedge REF_CLK_I) disable iff (!ARST_N_I)
    FRAME_EXEC_O |=> !FRAME_EXEC_O) else $error("exec too long");
  a_code_on_exec: assert property (
    @(posedge REF_CLK_I) disable iff (!ARST_N_I)
    $changed(CH_CODE_O) |-> FRAME_EXEC_O) else $error("code moved");
  a_mode_on_exec: assert property (
    @(posedge REF_CLK_I) disable iff (!ARST_N_I)
    $changed(WRITE_THROUGH_O) |-> FRAME_EXEC_O) else $error("mode moved");
  a_down_on_exec: assert property (
    @(posedge REF_CLK_I) disable iff (!ARST_N_I)
    $changed(CH_DOWN_O) |-> FRAME_EXEC_O) else $error("down moved");
  a_down_unsettled: assert property (
    @(posedge REF_CLK_I) disable iff (!ARST_N_I)
    (CH_DOWN_O & CH_SETTLED_O) == 8'h00) else $error("down yet settled");
  a_dout_quiet: assert property (
    @(posedge SCLK_I) disable iff (!ARST_N_I || SYNC_N_I)
    cnt != 5'h00 && cnt < 5'h0F |-> !DOUT_O) else $error("chain not low");
  a_dout_mark: assert property (
    @(posedge SCLK_I) disable iff (!ARST_N_I || SYNC_N_I)
    cnt == 5'h0F |-> DOUT_O) else $error("chain mark missing");
  a_dout_forward: assert property (
    @(posedge SCLK_I) disable iff (!ARST_N_I || SYNC_N_I)
    cnt >= 5'h10 |-> DOUT_O == hist[15]) else $error("chain bit wrong");
  c_exec: cover property (@(posedge REF_CLK_I) FRAME_EXEC_O);
  c_chain: cover property (@(posedge SCLK_I) cnt == 5'h1F);
  c_wt: cover property (@(posedge REF_CLK_I) $rose(WRITE_THROUGH_O));
endmodule
bind dac_serial_port dac_port_monitor i_mon (.REF_CLK_I(REF_CLK_I),
  .ARST_N_I(ARST_N_I), .SCLK_I(SCLK_I), .SYNC_N_I(SYNC_N_I), .DIN_I(DIN_I),
  .DOUT_O(DOUT_O), .CH_CODE_O(CH_CODE_O), .CH_DOWN_O(CH_DOWN_O),
  .CH_SETTLED_O(CH_SETTLED_O), .WRITE_THROUGH_O(WRITE_THROUGH_O),
  .FRAME_EXEC_O(FRAME_EXEC_O));
`default_nettype wire

// [test/dac_host_model.sv]
// Host model driving the serial link of the DAC port
`timescale 1ns/1ps
`default_nettype none
module dac_host_model (
  // Link
  output logic sclk_o,
  output logic sync_n_o,
  output logic din_o
);
  initial begin
    sclk_o = 1'b1;
    sync_n_o = 1'b1;
    din_o = 1'b0;
  end
  // Sends word[n-1:0] top bit first, 32 ns a bit
  task automatic send(input logic [31:0] word, input int n);
    #40 sync_n_o = 1'b0;
    #8;
    for (int i = n - 1; i >= 0; i--) begin
      din_o = word[i];
      #8 sclk_o = 1'b0;
      #16 sclk_o = 1'b1;
      #8;
    end
    sync_n_o = 1'b1;
    din_o = ~din_o;
  endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the DAC serial command port
`timescale 1ns/1ps
`default_nettype none
module testbench
  import dac_cmd_pkg::*;
;
  typedef struct packed {
    frame_t w;
    logic [2:0] ch;
    logic [11:0] code;
    logic wt;
  } row_t;
  row_t rows [9] = '{
    {16'h0123, 3'h0, 12'h000, 1'h0}, {16'h1456, 3'h1, 12'h000, 1'h0},
    {16'hA103, 3'h0, 12'h123, 1'h0}, {16'h9000, 3'h1, 12'h456, 1'h1},
    {16'h7ABC, 3'h7, 12'hABC, 1'h1}, {16'h8FFF, 3'h7, 12'hABC, 1'h0},
    {16'h2777, 3'h2, 12'h000, 1'h0}, {16'hB321, 3'h2, 12'h777, 1'h0},
    {16'hC5A5, 3'h4, 12'h5A5, 1'h0}};
  logic clk, arst_n, dout, wt, reg_en, exec, hit;
  wire logic sclk, sync_n, din;
  code_arr_t code;
  logic [CH_NUM-1:0] down, settled;
  term_arr_t term;
  int err_count = 0;
  int checks = 0;
  ////////////////////////////////////////////////////////////////////////////
  dac_host_model i_host (.sclk_o(sclk), .sync_n_o(sync_n), .din_o(din));
  dac_serial_port i_dut (.REF_CLK_I(clk), .ARST_N_I(arst_n),
    .SCLK_I(sclk), .SYNC_N_I(sync_n), .DIN_I(din), .DOUT_O(dout),
    .CH_CODE_O(code), .CH_DOWN_O(down), .CH_TERM_O(term),
    .CH_SETTLED_O(settled), .WRITE_THROUGH_O(wt),
    .REGULATOR_EN_O(reg_en), .FRAME_EXEC_O(exec));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic frame(input logic [31:0] w, input int n);
    i_host.send(w, n);
    hit = 1'b0;
    repeat (12) @(negedge clk) if (exec === 1'b1) hit = 1'b1;
  endtask
  task automatic summarize;
    $display("err_count %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    err_count++;
    summarize;
  end
  initial begin
    arst_n = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(negedge clk);
    check(12'(settled), 12'h0FF);
    check(12'(wt), 12'h000);
    check(code[3], 12'h000);
    foreach (rows[i]) begin
      frame(32'(rows[i].w), FRAME_BITS);
      check(12'(hit), 12'h001);
      check(code[rows[i].ch], rows[i].code);
      check(12'(wt), 12'(rows[i].wt));
    end
    check(12'(reg_en), 12'h001);
    frame(32'h0000C111, 0);
    check(12'(hit), 12'h000);
    for (int n = 14; n < 16; n++) begin
      frame(32'h0000C111, n);
      check(12'(hit), 12'h000);
      check(code[4], 12'h5A5);
    end
    frame(32'hC444C333, 32);
    check(code[4], 12'h333);
    for (int k = 1; k < 4; k++) begin
      frame({16'h0000, 4'(k + 12), 12'h001}, FRAME_BITS);
      check(12'(term[0]), 12'(k));
      check(12'(down[0]), 12'h001);
    end
    frame(32'h0000C0FF, FRAME_BITS);
    check(code[0], 12'h0FF);
    frame(32'h0000D000, FRAME_BITS);
    check(12'(term[0]), 12'h000);
    repeat (1980) @(negedge clk);
    check(12'(settled[0]), 12'h000);
    repeat (40) @(negedge clk);
    check(12'(settled[0]), 12'h001);
    frame(32'h00009000, FRAME_BITS);
    check(12'(wt), 12'h001);
    @(posedge clk) arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(negedge clk);
    check(12'(wt), 12'h000);
    frame(32'h00000ABC, FRAME_BITS);
    check(12'(hit), 12'h001);
    check(code[0], 12'h000);
    summarize;
  end
endmodule
`default_nettype wire
